//--- common/arr_pkg.sv
package arr_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int ADDR_W = 7;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_SRC = 7'h1d;
  localparam logic [ADDR_W-1:0] ADDR_RANGE_AB = 7'h1e;
  localparam logic [ADDR_W-1:0] ADDR_RANGE_CD = 7'h1f;
  localparam logic [ADDR_W-1:0] ADDR_ADC_FIRST = 7'h20;
  localparam logic [ADDR_W-1:0] ADDR_ADC_LAST = 7'h49;

  // ************************************************************
  // field layout
  // ************************************************************
  localparam int DATA_W = 8;
  localparam int ALARM_N = 4;
  localparam int LATCH_DIS_BIT = 4;
  localparam int RANGE_W = 3;
  localparam int RANGE_HI_LSB = 4;
  localparam int RANGE_LO_LSB = 0;
  localparam int RANGE_EXPLICIT_BIT = 2;
  localparam int RESULT_W = 12;
  localparam int RESULT_LO_W = 8;
  localparam int ADC_CHANNELS = 21;
  localparam int CHAN_W = 5;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [ALARM_N-1:0] SEL_RESET = 4'h0;
  localparam logic LATCH_DIS_RESET = 1'b0;
  localparam logic [RANGE_W-1:0] RANGE_CODE_RESET = 3'h0;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  // ************************************************************
  // decoded output range, order follows codes 100 to 111
  // ************************************************************
  typedef enum logic [1:0] {
    ARR_RNG_NEG10,
    ARR_RNG_NEG5,
    ARR_RNG_POS10,
    ARR_RNG_POS5
  } arr_range_t;

  localparam arr_range_t RANGE_RESET = ARR_RNG_NEG10;

endpackage

//--- rtl/arr_range_resolve.sv
`timescale 1ns/1ps
module arr_range_resolve
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [arr_pkg::RANGE_W-1:0] range_code,
  input wire arr_pkg::arr_range_t auto_range,
  output arr_pkg::arr_range_t range_q
);
  import arr_pkg::*;

  // ************************************************************
  // explicit code beats the auto-range detector
  // ************************************************************
  wire explicit_sel;
  arr_range_t coded_range;
  arr_range_t range_d;

  assign explicit_sel = range_code[RANGE_EXPLICIT_BIT];
  assign coded_range = arr_range_t'(range_code[RANGE_EXPLICIT_BIT-1:0]);
  assign range_d = explicit_sel ? coded_range : auto_range;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      range_q <= RANGE_RESET;
    else
      range_q <= range_d;
  end

endmodule

//--- rtl/arr_regs.sv
`timescale 1ns/1ps
// Operation
// - latch disable clear: alarms latch set
// - latched bit clears only after read, condition gone
// - latch disable set: bits not latched
// - unlatched bit clears when condition subsides
// - bits 3-0 pick alarms driving pin
// - pin reacts only while output enabled
// - 0x1E bits 6-4 hold group B
// - 0x1E bits 2-0 hold group A
// - 0x1F holds group D high, C low
// - group C same coding, reserved zero
// - explicit code overrides auto-range result
// - code 0xx uses auto-range result
// - codes 100..111 map to four ranges
// - results kept as straight binary
// - result byte pairs at 0x20..0x49
// - reserved bits read as zero
module arr_regs
#(
  parameter int ADC_CHANNELS = arr_pkg::ADC_CHANNELS
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [arr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [arr_pkg::DATA_W-1:0] reg_wdata,
  output logic [arr_pkg::DATA_W-1:0] reg_rdata_q,
  output logic reg_rvalid_q,
  input wire logic [arr_pkg::ALARM_N-1:0] alarm_cond,
  input wire logic alarm_status_read,
  input wire logic alarm_output_enable,
  output logic [arr_pkg::ALARM_N-1:0] alarm_status_q,
  output logic alarm_output_pin_q,
  output logic alarm_latch_disable_q,
  input wire arr_pkg::arr_range_t auto_range_a,
  input wire arr_pkg::arr_range_t auto_range_b,
  input wire arr_pkg::arr_range_t auto_range_c,
  input wire arr_pkg::arr_range_t auto_range_d,
  output arr_pkg::arr_range_t group_a_range_q,
  output arr_pkg::arr_range_t group_b_range_q,
  output arr_pkg::arr_range_t group_c_range_q,
  output arr_pkg::arr_range_t group_d_range_q,
  input wire logic adc_wb_valid,
  input wire logic [arr_pkg::CHAN_W-1:0] adc_wb_chan,
  input wire logic [arr_pkg::RESULT_W-1:0] adc_wb_data
);
  import arr_pkg::*;

  // ************************************************************
  // storage
  // ************************************************************
  logic [ALARM_N-1:0] pin_sel_q;
  logic [RANGE_W-1:0] group_a_range_code;
  logic [RANGE_W-1:0] group_b_range_code;
  logic [RANGE_W-1:0] group_c_range_code;
  logic [RANGE_W-1:0] group_d_range_code;
  logic [RESULT_W-1:0] conversion_result [ADC_CHANNELS];

  // ************************************************************
  // address decode
  // ************************************************************
  wire alarm_src_hit;
  wire range_ab_hit;
  wire range_cd_hit;
  wire adc_hit;
  wire adc_high_sel;
  wire [ADDR_W-1:0] adc_off;
  wire [CHAN_W-1:0] adc_idx;
  wire adc_idx_ok;
  wire wb_ok;

  assign alarm_src_hit = reg_addr == ADDR_ALARM_SRC;
  assign range_ab_hit = reg_addr == ADDR_RANGE_AB;
  assign range_cd_hit = reg_addr == ADDR_RANGE_CD;
  assign adc_hit = (reg_addr >= ADDR_ADC_FIRST) && (reg_addr <= ADDR_ADC_LAST);
  assign adc_off = reg_addr - ADDR_ADC_FIRST;
  assign adc_idx = adc_off[CHAN_W:1];
  assign adc_high_sel = adc_off[0];
  assign adc_idx_ok = adc_hit && (32'(adc_idx) < ADC_CHANNELS);
  assign wb_ok = adc_wb_valid && (32'(adc_wb_chan) < ADC_CHANNELS);

  // ************************************************************
  // alarm latching
  // ************************************************************
  logic [ALARM_N-1:0] alarm_status_d;
  wire [ALARM_N-1:0] latched_next;

  // a live condition keeps the bit set even in the reading cycle
  assign latched_next = alarm_cond | (alarm_status_q & ~{ALARM_N{alarm_status_read}});
  assign alarm_status_d = alarm_latch_disable_q ? alarm_cond : latched_next;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      alarm_status_q <= SEL_RESET;
    else
      alarm_status_q <= alarm_status_d;
  end

  // ************************************************************
  // alarm output pin
  // ************************************************************
  wire pin_d;

  assign pin_d = alarm_output_enable && |(alarm_status_q & pin_sel_q);

  always_ff @(posedge clk)
  begin
    if (!resetn)
      alarm_output_pin_q <= 1'b0;
    else
      alarm_output_pin_q <= pin_d;
  end

  // ************************************************************
  // host writes
  // ************************************************************
  wire wr_alarm_src;
  wire wr_range_ab;
  wire wr_range_cd;

  assign wr_alarm_src = reg_wr && alarm_src_hit;
  assign wr_range_ab = reg_wr && range_ab_hit;
  assign wr_range_cd = reg_wr && range_cd_hit;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pin_sel_q <= SEL_RESET;
      alarm_latch_disable_q <= LATCH_DIS_RESET;
    end
    else if (wr_alarm_src)
    begin
      pin_sel_q <= reg_wdata[ALARM_N-1:0];
      alarm_latch_disable_q <= reg_wdata[LATCH_DIS_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      group_a_range_code <= RANGE_CODE_RESET;
      group_b_range_code <= RANGE_CODE_RESET;
    end
    else if (wr_range_ab)
    begin
      group_a_range_code <= reg_wdata[RANGE_LO_LSB +: RANGE_W];
      group_b_range_code <= reg_wdata[RANGE_HI_LSB +: RANGE_W];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      group_c_range_code <= RANGE_CODE_RESET;
      group_d_range_code <= RANGE_CODE_RESET;
    end
    else if (wr_range_cd)
    begin
      group_c_range_code <= reg_wdata[RANGE_LO_LSB +: RANGE_W];
      group_d_range_code <= reg_wdata[RANGE_HI_LSB +: RANGE_W];
    end
  end

  // ************************************************************
  // conversion result writeback, host writes never reach it
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < ADC_CHANNELS; i++)
        conversion_result[i] <= RESULT_RESET;
    end
    else if (wb_ok)
      conversion_result[adc_wb_chan] <= adc_wb_data;
  end

  // ************************************************************
  // read path
  // ************************************************************
  wire [DATA_W-1:0] alarm_src_byte;
  wire [DATA_W-1:0] range_ab_byte;
  wire [DATA_W-1:0] range_cd_byte;
  wire [RESULT_W-1:0] adc_word;
  wire [DATA_W-1:0] adc_byte;
  wire [DATA_W-1:0] rdata_d;

  assign alarm_src_byte = DATA_W'(pin_sel_q) | (DATA_W'(alarm_latch_disable_q) << LATCH_DIS_BIT);
  assign range_ab_byte = (DATA_W'(group_b_range_code) << RANGE_HI_LSB)
    | (DATA_W'(group_a_range_code) << RANGE_LO_LSB);
  assign range_cd_byte = (DATA_W'(group_d_range_code) << RANGE_HI_LSB)
    | (DATA_W'(group_c_range_code) << RANGE_LO_LSB);
  assign adc_word = adc_idx_ok ? conversion_result[adc_idx] : RESULT_RESET;
  assign adc_byte = adc_high_sel ? DATA_W'(adc_word[RESULT_W-1:RESULT_LO_W])
    : adc_word[RESULT_LO_W-1:0];
  assign rdata_d = alarm_src_hit ? alarm_src_byte
    : range_ab_hit ? range_ab_byte
    : range_cd_hit ? range_cd_byte
    : adc_hit ? adc_byte
    : BYTE_ZERO;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      reg_rdata_q <= BYTE_ZERO;
      reg_rvalid_q <= 1'b0;
    end
    else
    begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd)
        reg_rdata_q <= rdata_d;
    end
  end

  // ************************************************************
  // range resolution per group
  // ************************************************************
  arr_range_resolve u_range_a
  (
    .clk(clk),
    .resetn(resetn),
    .range_code(group_a_range_code),
    .auto_range(auto_range_a),
    .range_q(group_a_range_q)
  );

  arr_range_resolve u_range_b
  (
    .clk(clk),
    .resetn(resetn),
    .range_code(group_b_range_code),
    .auto_range(auto_range_b),
    .range_q(group_b_range_q)
  );

  arr_range_resolve u_range_c
  (
    .clk(clk),
    .resetn(resetn),
    .range_code(group_c_range_code),
    .auto_range(auto_range_c),
    .range_q(group_c_range_q)
  );

  arr_range_resolve u_range_d
  (
    .clk(clk),
    .resetn(resetn),
    .range_code(group_d_range_code),
    .auto_range(auto_range_d),
    .range_q(group_d_range_q)
  );

  // ************************************************************
  // checks
  // ************************************************************
  latch_set_a: assert property (@(posedge clk) disable iff (!resetn)
    !alarm_latch_disable_q |=> ((alarm_status_q & $past(alarm_cond)) == $past(alarm_cond)))
    else $error("latched alarm did not set");

  latch_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    (!alarm_latch_disable_q && !alarm_status_read)
    |=> ((alarm_status_q & $past(alarm_status_q)) == $past(alarm_status_q)))
    else $error("latched alarm cleared without read");

  latch_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    (!alarm_latch_disable_q && alarm_status_read) |=> alarm_status_q == $past(alarm_cond))
    else $error("read did not clear resolved alarms");

  follow_live_a: assert property (@(posedge clk) disable iff (!resetn)
    alarm_latch_disable_q |=> alarm_status_q == $past(alarm_cond))
    else $error("unlatched alarm did not follow condition");

  pin_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    !alarm_output_enable |=> !alarm_output_pin_q)
    else $error("alarm pin active while disabled");

  pin_select_a: assert property (@(posedge clk) disable iff (!resetn)
    alarm_output_enable |=> alarm_output_pin_q == |($past(alarm_status_q) & $past(pin_sel_q)))
    else $error("alarm pin does not match selected alarms");

  range_override_a: assert property (@(posedge clk) disable iff (!resetn)
    group_b_range_code[RANGE_EXPLICIT_BIT]
    |=> group_b_range_q == arr_range_t'($past(group_b_range_code[1:0])))
    else $error("explicit range code not applied");

  range_auto_a: assert property (@(posedge clk) disable iff (!resetn)
    !group_c_range_code[RANGE_EXPLICIT_BIT] |=> group_c_range_q == $past(auto_range_c))
    else $error("auto range not used for code 0xx");

  adc_read_a: assert property (@(posedge clk) disable iff (!resetn)
    (reg_rd && adc_idx_ok && !adc_high_sel)
    ##1 reg_rvalid_q |-> reg_rdata_q == $past(adc_word[RESULT_LO_W-1:0]))
    else $error("result low byte read wrong");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!resetn)
    $past(reg_rd && adc_hit && adc_high_sel) |-> reg_rdata_q[DATA_W-1:RESULT_W-RESULT_LO_W] == '0)
    else $error("result high byte reserved bits not zero");

  result_ro_a: assert property (@(posedge clk) disable iff (!resetn)
    (reg_wr && adc_idx_ok && !adc_wb_valid)
    |=> conversion_result[$past(adc_idx)] == $past(adc_word))
    else $error("host write changed a conversion result");

endmodule

//--- verif/arr_host.sv
`timescale 1ns/1ps
module arr_host
(
  input wire logic clk,
  input wire logic [arr_pkg::DATA_W-1:0] reg_rdata_q,
  input wire logic reg_rvalid_q,
  output logic [arr_pkg::ADDR_W-1:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [arr_pkg::DATA_W-1:0] reg_wdata
);
  import arr_pkg::*;

  // ****************************************
  // idle bus, strobes low
  // ****************************************
  initial
  begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // ****************************************
  // one-cycle strobes, released bus inverted
  // ****************************************
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    // valid must stand one cycle after the strobe, else the data is unknown
    d = (reg_rvalid_q === 1'b1) ? reg_rdata_q : 8'hxx;
  endtask
endmodule

//--- verif/arr_regs_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %h exp %h", $time, a, e); end end
module arr_regs_test;
  import arr_pkg::*;
  logic clk, resetn, reg_wr, reg_rd, reg_rvalid_q, alarm_status_read, alarm_output_enable;
  logic alarm_output_pin_q, alarm_latch_disable_q, adc_wb_valid;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_q, v;
  logic [3:0] alarm_cond, alarm_status_q;
  logic [4:0] adc_wb_chan;
  logic [11:0] adc_wb_data;
  arr_range_t au [4];
  arr_range_t rng [4];
  int mismatches, n_compared, r1e, r1f, res [21];

  arr_regs arr_regs_inst (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .alarm_cond(alarm_cond),
    .alarm_status_read(alarm_status_read), .alarm_output_enable(alarm_output_enable),
    .alarm_status_q(alarm_status_q), .alarm_output_pin_q(alarm_output_pin_q),
    .alarm_latch_disable_q(alarm_latch_disable_q), .auto_range_a(au[0]),
    .auto_range_b(au[1]), .auto_range_c(au[2]), .auto_range_d(au[3]),
    .group_a_range_q(rng[0]), .group_b_range_q(rng[1]), .group_c_range_q(rng[2]),
    .group_d_range_q(rng[3]), .adc_wb_valid(adc_wb_valid), .adc_wb_chan(adc_wb_chan),
    .adc_wb_data(adc_wb_data));
  arr_host arr_host_inst (.clk(clk), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

  // ****************************************
  // helpers
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse_read();
    alarm_status_read = 1'b1;
    cyc(1);
    alarm_status_read = 1'b0;
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  task automatic range_test();
    int c, e;
    for (int k = 0; k < 8; k++)
    begin
      r1e = k * 17;
      r1f = (7 - k) * 17;
      arr_host_inst.wr(ADDR_RANGE_AB, 8'(r1e));
      arr_host_inst.wr(ADDR_RANGE_CD, 8'(r1f));
      for (int i = 0; i < 4; i++)
        au[i] = arr_range_t'($urandom % 4);
      cyc(2);
      for (int i = 0; i < 4; i++)
      begin
        c = ((i < 2 ? r1e : r1f) >> (4 * (i % 2))) & 7;
        e = c[2] ? c & 3 : int'(au[i]);
        `CHK(rng[i], 2'(e))
      end
      arr_host_inst.rd(ADDR_RANGE_AB, v);
      `CHK(v, 8'(r1e))
      arr_host_inst.rd(ADDR_RANGE_CD, v);
      `CHK(v, 8'(r1f))
    end
    $display("range test done");
  endtask

  task automatic adc_test();
    int ch;
    for (int k = 0; k < 10; k++)
    begin
      ch = $urandom % 21;
      res[ch] = $urandom % 4096;
      adc_wb_chan = 5'(ch);
      adc_wb_data = 12'(res[ch]);
      adc_wb_valid = 1'b1;
      cyc(1);
      adc_wb_chan = 5'(21 + k);
      adc_wb_data = 12'hfff;
      cyc(1);
      adc_wb_valid = 1'b0;
      arr_host_inst.wr(7'(ADDR_ADC_FIRST + 2 * ch), 8'h5a);
    end
    for (int i = 0; i < 21; i++)
    begin
      arr_host_inst.rd(7'(ADDR_ADC_FIRST + 2 * i), v);
      `CHK(v, 8'(res[i] & 255))
      arr_host_inst.rd(7'(ADDR_ADC_FIRST + 2 * i + 1), v);
      `CHK(v, 8'(res[i] >> 8))
    end
    arr_host_inst.rd(7'h4a, v);
    `CHK(v, 8'h00)
    $display("adc test done");
  endtask

  task automatic alarm_test(input int dis, input logic en);
    int sel;
    sel = $urandom % 16;
    alarm_output_enable = en;
    arr_host_inst.wr(ADDR_ALARM_SRC, 8'(dis * 16 + sel));
    arr_host_inst.rd(ADDR_ALARM_SRC, v);
    `CHK(v, 8'(dis * 16 + sel))
    `CHK(alarm_latch_disable_q, 1'(dis))
    for (int i = 0; i < 4; i++)
    begin
      alarm_cond = 4'(1 << i);
      cyc(3);
      `CHK(alarm_status_q, 4'(1 << i))
      `CHK(alarm_output_pin_q, 1'(en & sel[i]))
      pulse_read();
      alarm_cond = 4'h0;
      cyc(3);
      `CHK(alarm_status_q, 4'(dis ? 0 : 1 << i))
      `CHK(alarm_output_pin_q, 1'(!dis & en & sel[i]))
      pulse_read();
      cyc(3);
      `CHK(alarm_status_q, 4'h0)
      `CHK(alarm_output_pin_q, 1'b0)
    end
    $display("alarm test done dis=%0d en=%0d", dis, en);
  endtask

  task automatic reset_test();
    alarm_cond = 4'h5;
    cyc(2);
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    alarm_cond = 4'h0;
    `CHK(alarm_status_q, 4'h0)
    `CHK(alarm_output_pin_q, 1'b0)
    foreach (rng[i])
      `CHK(rng[i], ARR_RNG_NEG10)
    for (int a = 8'h1d; a < 8'h22; a++)
    begin
      arr_host_inst.rd(7'(a), v);
      `CHK(v, 8'h00)
    end
    $display("mid-run reset test done");
  endtask

  // ****************************************
  // clock, reset, sequence, watchdog
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    #1000000;
    mismatches++;
    close_out();
  end

  initial
  begin
    void'($urandom(21));
    resetn = 1'b0;
    alarm_cond = 4'h0;
    alarm_status_read = 1'b0;
    alarm_output_enable = 1'b0;
    adc_wb_valid = 1'b0;
    adc_wb_chan = 5'h00;
    adc_wb_data = 12'h000;
    for (int i = 0; i < 4; i++)
      au[i] = ARR_RNG_POS5;
    for (int i = 0; i < 21; i++)
      res[i] = 0;
    cyc(2);
    resetn = 1'b1;
    foreach (au[i])
      `CHK(rng[i], ARR_RNG_NEG10)
    for (int a = 8'h1c; a < 8'h24; a++)
    begin
      arr_host_inst.rd(7'(a), v);
      `CHK(v, 8'h00)
    end
    $display("reset test done");
    range_test();
    adc_test();
    alarm_test(0, 1'b1);
    alarm_test(1, 1'b1);
    alarm_test(0, 1'b0);
    reset_test();
    close_out();
  end
endmodule
